// ### design/spi_flag_pkg.sv
// constants shared by the spi status and interrupt flag logic
package spi_flag_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int EVT_W  = 4;

  // ---------------------------------------------------------------
  // register offsets on the plain register port
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 3'h0; // serial_port_control
  localparam logic [ADDR_W-1:0] STAT_OFS = 3'h1; // serial_port_status_control
  localparam logic [ADDR_W-1:0] DATA_OFS = 3'h2; // rx on read, tx on write
  localparam logic [ADDR_W-1:0] EVST_OFS = 3'h3; // sticky event status, w1c
  localparam logic [ADDR_W-1:0] EVMK_OFS = 3'h4; // event mask

  // ---------------------------------------------------------------
  // serial_port_control fields
  // ---------------------------------------------------------------
  localparam int CTRL_RXIE = 7; // rx_irq_enable
  localparam int CTRL_DMAS = 6; // tx request goes to dma instead of cpu
  localparam int CTRL_MSTR = 5; // master mode
  localparam int CTRL_TXIE = 0; // tx_irq_enable
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

  // ---------------------------------------------------------------
  // serial_port_status_control fields
  // ---------------------------------------------------------------
  localparam int STAT_RXF  = 7; // rx_full_flag
  localparam int STAT_ERIE = 6; // error_irq_enable
  localparam int STAT_OVR  = 5; // overrun_flag
  localparam int STAT_MODE_FAULT_FLAG = 4; // mode_fault_flag
  localparam int STAT_TXE  = 3; // tx_empty_flag
  localparam int STAT_MFEN = 2; // mode_fault_detect_enable

  // ---------------------------------------------------------------
  // event status and mask layout
  // ---------------------------------------------------------------
  localparam int EV_RX   = 0;
  localparam int EV_OVR  = 1;
  localparam int EV_MODE_FAULT_FLAG = 2;
  localparam int EV_TX   = 3;
  localparam logic [EVT_W-1:0] EVST_RST = 4'h0;
  localparam logic [EVT_W-1:0] EVMK_RST = 4'h0;

endpackage : spi_flag_pkg

// ### design/spi_status_flag_logic.sv
// spi receiver, overrun, mode fault and transmitter flags with requests
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - a byte moved from shifter to receive register sets rx_full_flag
// - cpu receive request while rx_full_flag and rx_irq_enable both set
// - rx_full_flag clears on status read with flag set then data read
// - reset clears rx_full_flag
// - overrun and mode fault request only with error_irq_enable, reset clear
// - new byte while receive register still unread sets overrun_flag
// - on overrun the held byte stays and the new byte is dropped
// - overrun_flag clears on status read with flag set then data read
// - slave with detect enabled: select rising mid transfer sets mode fault
// - master with detect enabled: select low sets mode fault at any time
// - mode fault clears on status read with flag set then control write
// - reset clears overrun_flag and mode_fault_flag
// - transmit register handing a byte to the shifter sets tx_empty_flag
// - tx_empty_flag with tx_irq_enable gives a cpu or dma request
// - a cpu write of the transmit data register clears tx_empty_flag
// - reset sets tx_empty_flag
module spi_status_flag_logic
  import spi_flag_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              rx_byte_done,
  input  wire logic [DATA_W-1:0] rx_shift_data,
  input  wire logic              tx_load,
  output logic      [DATA_W-1:0] tx_data,
  output logic                   tx_pending,
  output logic                   master_mode,
  input  wire logic              ss_n,
  input  wire logic              sck,
  output logic                   rx_irq_req,
  output logic                   err_irq_req,
  output logic                   tx_irq_req,
  output logic                   tx_dma_req,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_reg;
  logic              err_en_reg;
  logic              mode_fault_flag_en_reg;
  logic              rx_full_reg;
  logic              ovr_reg;
  logic              mode_fault_flag_reg;
  logic              tx_empty_reg;
  logic              rx_arm_reg;
  logic              ovr_arm_reg;
  logic              mode_fault_flag_arm_reg;
  logic [DATA_W-1:0] rx_data_reg;
  logic [DATA_W-1:0] tx_data_reg;
  logic [EVT_W-1:0]  evst_reg;
  logic [EVT_W-1:0]  evmk_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              xfer_reg;
  logic              ss_meta;
  logic              ss_sync;
  logic              ss_dly;
  logic              sck_meta;
  logic              sck_sync;
  logic              sck_dly;

  logic              wr_ctrl;
  logic              wr_stat;
  logic              wr_data;
  logic              wr_evst;
  logic              wr_evmk;
  logic              rd_stat;
  logic              rd_data;
  logic              rx_clr;
  logic              rx_set;
  logic              ovr_set;
  logic              ovr_clr;
  logic              mode_fault_flag_set;
  logic              mode_fault_flag_clr;
  logic              ss_rise;
  logic              sck_edge;
  logic [EVT_W-1:0]  ev_set;
  logic [EVT_W-1:0]  evst_next;
  logic [DATA_W-1:0] stat_view;
  logic [DATA_W-1:0] rdata_next;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // select and serial clock come from the far device; three flops each,
  // and only the second flop and later are looked at
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ss_meta  <= 1'b1;
      ss_sync  <= 1'b1;
      ss_dly   <= 1'b1;
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_dly  <= 1'b0;
    end else begin
      ss_meta  <= ss_n;
      ss_sync  <= ss_meta;
      ss_dly   <= ss_sync;
      sck_meta <= sck;
      sck_sync <= sck_meta;
      sck_dly  <= sck_sync;
    end
  end

  assign ss_rise  = ss_sync && !ss_dly;
  assign sck_edge = sck_sync ^ sck_dly;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  assign wr_ctrl = wr_en && (addr == CTRL_OFS);
  assign wr_stat = wr_en && (addr == STAT_OFS);
  assign wr_data = wr_en && (addr == DATA_OFS);
  assign wr_evst = wr_en && (addr == EVST_OFS);
  assign wr_evmk = wr_en && (addr == EVMK_OFS);
  assign rd_stat = rd_en && (addr == STAT_OFS);
  assign rd_data = rd_en && (addr == DATA_OFS);

  // ---------------------------------------------------------------
  // software settings
  // ---------------------------------------------------------------
  // control and the two writable status bits; reset leaves error
  // requests disabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg    <= CTRL_RST;
      err_en_reg  <= 1'b0;
      mode_fault_flag_en_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata;
      end
      if (wr_stat) begin
        err_en_reg  <= wdata[STAT_ERIE];
        mode_fault_flag_en_reg <= wdata[STAT_MFEN];
      end
    end
  end

  assign master_mode = ctrl_reg[CTRL_MSTR];

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  // a byte that lands in the same cycle as the clearing data read is
  // accepted as fresh data: the old byte has been taken by that read
  assign rx_clr  = rd_data && rx_arm_reg;
  assign rx_set  = rx_byte_done && (!rx_full_reg || rx_clr);
  assign ovr_set = rx_byte_done && rx_full_reg && !rx_clr;
  assign ovr_clr = rd_data && ovr_arm_reg;

  // receive flag; set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_full_reg <= 1'b0;
    end else if (rx_set) begin
      rx_full_reg <= 1'b1;
    end else if (rx_clr) begin
      rx_full_reg <= 1'b0;
    end
  end

  // held byte is only replaced when not overrunning
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_data_reg <= '0;
    end else if (rx_set) begin
      rx_data_reg <= rx_shift_data;
    end
  end

  // overrun flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovr_reg <= 1'b0;
    end else if (ovr_set) begin
      ovr_reg <= 1'b1;
    end else if (ovr_clr) begin
      ovr_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // clearing sequence arms
  // ---------------------------------------------------------------
  // a status read with the flag set arms; the matching access disarms
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_arm_reg   <= 1'b0;
      ovr_arm_reg  <= 1'b0;
      mode_fault_flag_arm_reg <= 1'b0;
    end else begin
      if (rd_stat && rx_full_reg) begin
        rx_arm_reg <= 1'b1;
      end else if (rd_data) begin
        rx_arm_reg <= 1'b0;
      end
      if (rd_stat && ovr_reg) begin
        ovr_arm_reg <= 1'b1;
      end else if (rd_data) begin
        ovr_arm_reg <= 1'b0;
      end
      if (rd_stat && mode_fault_flag_reg) begin
        mode_fault_flag_arm_reg <= 1'b1;
      end else if (wr_ctrl) begin
        mode_fault_flag_arm_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // mode fault
  // ---------------------------------------------------------------
  // slave transfer in progress: first serial clock edge with select
  // low until the byte completes or select goes away
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xfer_reg <= 1'b0;
    end else if (master_mode || ss_sync || rx_byte_done) begin
      xfer_reg <= 1'b0;
    end else if (sck_edge) begin
      xfer_reg <= 1'b1;
    end
  end

  // a master keeps faulting while select stays low, so the clear only
  // sticks once the pin is released
  assign mode_fault_flag_set = mode_fault_flag_en_reg &&
                    (master_mode ? !ss_sync
                                 : (ss_rise && xfer_reg));
  assign mode_fault_flag_clr = wr_ctrl && mode_fault_flag_arm_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_fault_flag_reg <= 1'b0;
    end else if (mode_fault_flag_set) begin
      mode_fault_flag_reg <= 1'b1;
    end else if (mode_fault_flag_clr) begin
      mode_fault_flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  // a write while the shifter still waits overwrites the pending byte;
  // software is trusted to wait for the empty flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_data_reg <= '0;
    end else if (wr_data) begin
      tx_data_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_empty_reg <= 1'b1;
    end else if (tx_load) begin
      tx_empty_reg <= 1'b1;
    end else if (wr_data) begin
      tx_empty_reg <= 1'b0;
    end
  end

  assign tx_data    = tx_data_reg;
  assign tx_pending = !tx_empty_reg;

  // ---------------------------------------------------------------
  // requests
  // ---------------------------------------------------------------
  assign rx_irq_req  = rx_full_reg && ctrl_reg[CTRL_RXIE];
  assign err_irq_req = err_en_reg && (ovr_reg || mode_fault_flag_reg);
  assign tx_irq_req  = tx_empty_reg && ctrl_reg[CTRL_TXIE] &&
                       !ctrl_reg[CTRL_DMAS];
  assign tx_dma_req  = tx_empty_reg && ctrl_reg[CTRL_TXIE] &&
                       ctrl_reg[CTRL_DMAS];

  // ---------------------------------------------------------------
  // sticky event status and mask
  // ---------------------------------------------------------------
  // a new event beats a write-one-to-clear in the same cycle
  always_comb begin
    ev_set          = '0;
    ev_set[EV_RX]   = rx_set;
    ev_set[EV_OVR]  = ovr_set;
    ev_set[EV_MODE_FAULT_FLAG] = mode_fault_flag_set && !mode_fault_flag_reg;
    ev_set[EV_TX]   = tx_load;
    evst_next       = evst_reg;
    if (wr_evst) begin
      evst_next = evst_next & ~wdata[EVT_W-1:0];
    end
    evst_next = evst_next | ev_set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evst_reg <= EVST_RST;
      evmk_reg <= EVMK_RST;
    end else begin
      evst_reg <= evst_next;
      if (wr_evmk) begin
        evmk_reg <= wdata[EVT_W-1:0];
      end
    end
  end

  assign irq = |(evst_reg & evmk_reg);

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    stat_view            = '0;
    stat_view[STAT_RXF]  = rx_full_reg;
    stat_view[STAT_ERIE] = err_en_reg;
    stat_view[STAT_OVR]  = ovr_reg;
    stat_view[STAT_MODE_FAULT_FLAG] = mode_fault_flag_reg;
    stat_view[STAT_TXE]  = tx_empty_reg;
    stat_view[STAT_MFEN] = mode_fault_flag_en_reg;
    rdata_next           = '0;
    unique case (addr)
      CTRL_OFS: rdata_next = ctrl_reg;
      STAT_OFS: rdata_next = stat_view;
      DATA_OFS: rdata_next = rx_data_reg;
      EVST_OFS: rdata_next = {{(DATA_W-EVT_W){1'b0}}, evst_reg};
      EVMK_OFS: rdata_next = {{(DATA_W-EVT_W){1'b0}}, evmk_reg};
      default:  rdata_next = '0; // unmapped reads as zero
    endcase
  end

  // rdata only stands in the cycle after a read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
    end else if (rd_en) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata = rdata_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_rx_full_set: assert property (@(posedge clk) disable iff (!resetn)
    rx_byte_done && !rx_full_reg |=> rx_full_reg &&
      rx_data_reg == $past(rx_shift_data))
    else $error("received byte did not set the full flag");

  a_rx_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
    $rose(rx_full_reg) |-> rx_irq_req == ctrl_reg[CTRL_RXIE])
    else $error("receive request not gated by its enable");

  a_rx_clear_seq: assert property (@(posedge clk) disable iff (!resetn)
    $fell(rx_full_reg) |-> $past(rd_data) && $past(rx_arm_reg))
    else $error("receive flag cleared without its sequence");

  a_err_gate: assert property (@(posedge clk) disable iff (!resetn)
    err_irq_req |-> err_en_reg && (ovr_reg || mode_fault_flag_reg))
    else $error("error request without enable or flag");

  a_ovr_keeps_byte: assert property (@(posedge clk) disable iff (!resetn)
    ovr_set |=> ovr_reg && $stable(rx_data_reg) && rx_full_reg)
    else $error("overrun disturbed the held byte");

  a_ovr_clear_seq: assert property (@(posedge clk) disable iff (!resetn)
    $fell(ovr_reg) |-> $past(rd_data) && $past(ovr_arm_reg))
    else $error("overrun cleared without its sequence");

  a_mode_fault_flag_master: assert property (@(posedge clk) disable iff (!resetn)
    master_mode && mode_fault_flag_en_reg && !ss_sync ##1 master_mode |-> mode_fault_flag_reg)
    else $error("master select low did not raise mode fault");

  a_mode_fault_flag_clear_seq: assert property (@(posedge clk) disable iff (!resetn)
    $fell(mode_fault_flag_reg) |-> $past(wr_ctrl) && $past(mode_fault_flag_arm_reg))
    else $error("mode fault cleared without its sequence");

  a_tx_empty_set: assert property (@(posedge clk) disable iff (!resetn)
    tx_load |=> tx_empty_reg ##0 (tx_pending == 1'b0))
    else $error("handoff to shifter did not set empty flag");

  a_tx_empty_clear: assert property (@(posedge clk) disable iff (!resetn)
    wr_data && !tx_load |=> !tx_empty_reg && tx_data == $past(wdata))
    else $error("data write did not clear empty flag");

  a_tx_request: assert property (@(posedge clk) disable iff (!resetn)
    tx_empty_reg && ctrl_reg[CTRL_TXIE] |-> tx_irq_req ^ tx_dma_req)
    else $error("transmit request missing or doubled");

  a_flag_holds: assert property (@(posedge clk) disable iff (!resetn)
    rx_full_reg && !rx_arm_reg |=> rx_full_reg)
    else $error("receive flag dropped before being armed");

endmodule : spi_status_flag_logic

// ### sim/spi_far_end.sv
// behavioural far-side spi master with a byte-level shift engine stand-in
`timescale 1ns/1ps
module spi_far_end (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       cut,
  input  wire logic [7:0] tx_byte,
  output logic            ss_n,
  output logic            sck,
  output logic            rx_byte_done,
  output logic [7:0]      rx_shift_data,
  output logic            tx_load,
  output logic            busy
);
  // ---------------------------------------------------------------
  // one frame per go pulse; sck stands still at 0 between frames
  // ---------------------------------------------------------------
  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    rx_byte_done = 1'b0;
    rx_shift_data = 8'h00;
    tx_load = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        ss_n <= 1'b0;
        tx_load <= 1'b1; // engine takes the pending transmit byte
        @(posedge clk);
        tx_load <= 1'b0;
        #1; // start the serial clock 1 ns after a bus clock edge; the 6th edge still lands on one
        // a cut frame stops half way, so select rises mid transfer
        repeat (cut ? 4 : 8) begin
          #62.5 sck = 1'b1;
          #62.5 sck = 1'b0;
        end
        @(posedge clk);
        if (!cut) begin
          rx_byte_done <= 1'b1;
          rx_shift_data <= tx_byte;
          @(posedge clk);
          rx_byte_done <= 1'b0;
          rx_shift_data <= ~tx_byte; // stale byte, no longer valid
        end
        ss_n <= 1'b1;
        repeat (6) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule // spi_far_end

// ### sim/spi_status_flag_logic_tb.sv
// self-checking bench for the spi status and interrupt flag logic
`timescale 1ns/1ps
module spi_status_flag_logic_tb;
  import spi_flag_pkg::*;
  logic              clk;
  logic              resetn;
  logic              wr_en;
  logic              rd_en;
  logic              go;
  logic              cut;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] tx_data;
  logic [DATA_W-1:0] rx_shift_data;
  logic [DATA_W-1:0] tbyte;
  logic [DATA_W-1:0] d;
  logic              rx_byte_done;
  logic              tx_load;
  logic              tx_pending;
  logic              master_mode;
  logic              ss_n;
  logic              sck;
  logic              rx_irq_req;
  logic              err_irq_req;
  logic              tx_irq_req;
  logic              tx_dma_req;
  logic              irq;
  logic              busy;
  int                err_count;
  int                cmp_count;

  spi_status_flag_logic u_spi_status_flag_logic (
    .clk, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata, .rx_byte_done,
    .rx_shift_data, .tx_load, .tx_data, .tx_pending, .master_mode, .ss_n,
    .sck, .rx_irq_req, .err_irq_req, .tx_irq_req, .tx_dma_req, .irq
  );

  spi_far_end u_spi_far_end (
    .clk, .go, .cut, .tx_byte(tbyte), .ss_n, .sck, .rx_byte_done,
    .rx_shift_data, .tx_load, .busy
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // writes land at the strobe edge; #1 lets level outputs settle
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic frame(input logic [7:0] b, input logic c);
    int i;
    @(posedge clk);
    tbyte <= b;
    cut <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (i = 0; i < 400 && busy; i++) @(posedge clk);
    if (busy) begin
      err_count++;
      $display("ERROR %0t: frame hung", $time);
      complete_run();
    end
    #1;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    go = 1'b0;
    cut = 1'b0;
    addr = '0;
    wdata = 8'h00;
    tbyte = 8'h00;
    err_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    // reset values and an unmapped address
    rd(STAT_OFS); chk(d, 8'h08);
    rd(CTRL_OFS); chk(d, 8'h00);
    chk({tx_pending, irq}, 8'h00);
    rd(3'h5); chk(d, 8'h00);
    $display("test reset done");
    // receive flag, its request and the armed clearing sequence
    wr(CTRL_OFS, 8'h80);
    frame(8'hA5, 1'b0);
    chk(rx_irq_req, 1'b1);
    rd(DATA_OFS); chk(d, 8'hA5);
    rd(STAT_OFS); chk(d, 8'h88);
    rd(DATA_OFS); chk(d, 8'hA5);
    rd(STAT_OFS); chk(d, 8'h08);
    chk({rx_irq_req, irq}, 8'h00);
    $display("test receive done");
    // two bytes unread: overrun keeps the first byte
    wr(STAT_OFS, 8'h40);
    frame(8'h11, 1'b0);
    frame(8'h22, 1'b0);
    rd(STAT_OFS); chk(d, 8'hE8);
    chk(err_irq_req, 1'b1);
    rd(DATA_OFS); chk(d, 8'h11);
    rd(STAT_OFS); chk(d, 8'h48);
    chk(err_irq_req, 1'b0);
    $display("test overrun done");
    // transmit side, tx_empty_flag is high before the write
    wr(DATA_OFS, 8'h5A);
    chk({7'h00, tx_pending}, 8'h01);
    chk(tx_data, 8'h5A);
    rd(STAT_OFS); chk(d, 8'h40);
    wr(CTRL_OFS, 8'h01);
    chk(tx_irq_req, 1'b0);
    frame(8'h00, 1'b0);
    chk({tx_pending, tx_irq_req}, 8'h01);
    wr(CTRL_OFS, 8'h41);
    chk({tx_irq_req, tx_dma_req}, 8'h01);
    rd(STAT_OFS); chk(d, 8'hC8);
    rd(DATA_OFS); chk(d, 8'h00);
    rd(STAT_OFS); chk(d, 8'h48);
    wr(CTRL_OFS, 8'h00);
    $display("test transmit done");
    // slave: select rises mid transfer
    wr(STAT_OFS, 8'h44);
    frame(8'h00, 1'b1);
    chk(err_irq_req, 1'b1);
    wr(CTRL_OFS, 8'h00);
    chk(err_irq_req, 1'b1);
    rd(STAT_OFS); chk(d, 8'h5C);
    wr(CTRL_OFS, 8'h00);
    rd(STAT_OFS); chk(d, 8'h4C);
    rd(EVST_OFS); chk(d, 8'h0F);
    $display("test slave fault done");
    // master: select driven low at all
    wr(CTRL_OFS, 8'h20);
    chk(master_mode, 1'b1);
    frame(8'h77, 1'b0);
    rd(STAT_OFS); chk(d & 8'h90, 8'h90);
    rd(DATA_OFS); chk(d, 8'h77);
    wr(CTRL_OFS, 8'h00);
    wr(STAT_OFS, 8'h40);
    $display("test master fault done");
    // event status, mask and the level interrupt
    wr(EVST_OFS, 8'h0F);
    rd(EVST_OFS); chk(d, 8'h00);
    wr(EVMK_OFS, 8'h01);
    chk(irq, 1'b0);
    frame(8'h3C, 1'b0);
    chk(irq, 1'b1);
    rd(EVST_OFS); chk(d, 8'h09);
    wr(EVMK_OFS, 8'h00);
    chk(irq, 1'b0);
    wr(EVMK_OFS, 8'h08);
    chk(irq, 1'b1);
    wr(EVST_OFS, 8'h08);
    chk(irq, 1'b0);
    rd(EVST_OFS); chk(d, 8'h01);
    $display("test interrupt done");
    complete_run();
  end
endmodule // spi_status_flag_logic_tb
